// ==== src/shps_defines.svh ====
`ifndef SHPS_DEFINES_SVH
`define SHPS_DEFINES_SVH
// Protocol select level that picks the two-wire protocol.
`define SHPS_SEL_I2C 1'b1
// Upper five bits of the seven-bit two-wire target address.
`define SHPS_ADDR_HI 5'h1a
// Cycles after reset before the synchronised pins and the clock edge detector hold real levels.
`define SHPS_SYNC_SETTLE 2'h3
// Serial link clock period in ns as seen on the bench.
`define SHPS_LINK_PERIOD_NS 800
// System clock period in ns.
`define SHPS_CLK_PERIOD_NS 100
`endif

// ==== src/shps_pkg.sv ====
package shps_pkg;
  // Port usage mode after the strap and the wire-count choice.
  typedef enum logic [2:0] {
    SHPS_I2C = 3'b001,
    SHPS_SPI3 = 3'b010,
    SHPS_SPI4 = 3'b100
  } shps_mode_e;
  // One open-drain or push-pull pin as output value and active-low enable.
  typedef struct packed {
    logic o;
    logic oe_n;
  } shps_pin_s;
endpackage

// ==== src/shps_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one pin.
module shps_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw and synchronised level.
  input wire logic d,
  output logic q
);
  logic meta;

  // The first flop feeds only the second, so metastability stays contained.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== src/shps_pin_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "shps_defines.svh"
module shps_pin_select
  import shps_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Straps and configuration.
  input wire logic protocol_select,
  input wire logic spi_four_wire,
  // Shared serial pins from the host side.
  input wire logic serial_clock_pin,
  input wire logic data_pin_in,
  input wire logic address_select_upper_in,
  input wire logic address_select_lower_pin,
  // Pin drivers, output enables active low.
  output logic data_pin_out,
  output logic data_pin_oe_n,
  output logic address_select_upper_out,
  output logic address_select_upper_oe_n,
  // Core side: mode, address and serial data.
  output logic i2c_mode,
  output logic [6:0] target_address,
  output logic chip_selected,
  output logic serial_clock_rise,
  output logic serial_clock_fall,
  output logic serial_data_in,
  input wire logic core_data_out,
  input wire logic core_data_drive,
  input wire logic core_sda_pull_low
);
  logic sel_s, sclk_s, sda_s, upper_s, lower_s, sclk_d;
  shps_mode_e mode, next_mode;
  shps_pin_s data_pin, upper_pin;

  // Every pin crosses into the clock domain through two flops.
  shps_sync u_sel (
    .clk(clk),
    .rst(rst),
    .d(protocol_select),
    .q(sel_s)
  );
  shps_sync u_sclk (
    .clk(clk),
    .rst(rst),
    .d(serial_clock_pin),
    .q(sclk_s)
  );
  shps_sync u_sda (
    .clk(clk),
    .rst(rst),
    .d(data_pin_in),
    .q(sda_s)
  );
  shps_sync u_upper (
    .clk(clk),
    .rst(rst),
    .d(address_select_upper_in),
    .q(upper_s)
  );
  shps_sync u_lower (
    .clk(clk),
    .rst(rst),
    .d(address_select_lower_pin),
    .q(lower_s)
  );

  // The synchronisers leave reset at zero while the strap idles high, so the mode
  // and the edge detector ignore them until real pin levels have arrived; otherwise
  // every reset would be followed by a false SPI phase and a false clock edge.
  logic [1:0] settle;
  wire settled = (settle == `SHPS_SYNC_SETTLE);

  // Mode decode; the strap is sampled continuously after synchronising.
  // The wire-count choice comes from logic on this clock, so it needs no flops.
  assign next_mode = (sel_s == `SHPS_SEL_I2C) ? SHPS_I2C :
                     (spi_four_wire ? SHPS_SPI4 : SHPS_SPI3);

  wire is_i2c = (mode == SHPS_I2C);
  wire is_spi3 = (mode == SHPS_SPI3);
  wire is_spi4 = (mode == SHPS_SPI4);
  wire cs_active = !is_i2c && !lower_s;
  wire sclk_rise = settled && sclk_s && !sclk_d;
  wire sclk_fall = settled && !sclk_s && sclk_d;

  // Data pin: open drain in two-wire mode, shared line in 3-wire, input only in 4-wire.
  always_comb begin
    data_pin.o = 1'b0;
    data_pin.oe_n = 1'b1;
    case (mode)
      SHPS_I2C: data_pin.oe_n = !core_sda_pull_low;
      SHPS_SPI3: begin
        data_pin.o = core_data_out;
        data_pin.oe_n = !(cs_active && core_data_drive);
      end
      SHPS_SPI4: data_pin.oe_n = 1'b1;
      default: data_pin.oe_n = 1'b1;
    endcase
  end

  // Upper address pin: input in two-wire mode, push-pull output in 4-wire SPI.
  always_comb begin
    upper_pin.o = 1'b0;
    upper_pin.oe_n = 1'b1;
    if (is_spi4) begin
      upper_pin.o = core_data_out;
      upper_pin.oe_n = !cs_active;
    end
  end

  // Mode register; reset lands in two-wire mode, the pulled-up strap default.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= SHPS_I2C;
      sclk_d <= 1'b0;
      settle <= 2'h0;
    end else begin
      // Two-wire mode is held until the strap level has crossed both flops.
      mode <= settled ? next_mode : SHPS_I2C;
      sclk_d <= sclk_s;
      // The count stops at its end value and stays there until the next reset.
      if (!settled) settle <= settle + 2'h1;
    end
  end

  // All outputs are registered, so pin drivers trail the mode by one cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_pin_out <= 1'b0;
      data_pin_oe_n <= 1'b1;
      address_select_upper_out <= 1'b0;
      address_select_upper_oe_n <= 1'b1;
      i2c_mode <= 1'b1;
      target_address <= 7'h00;
      chip_selected <= 1'b0;
      serial_clock_rise <= 1'b0;
      serial_clock_fall <= 1'b0;
      serial_data_in <= 1'b0;
    end else begin
      data_pin_out <= data_pin.o;
      data_pin_oe_n <= data_pin.oe_n;
      address_select_upper_out <= upper_pin.o;
      address_select_upper_oe_n <= upper_pin.oe_n;
      i2c_mode <= is_i2c;
      target_address <= is_i2c ? {`SHPS_ADDR_HI, upper_s, lower_s} : 7'h00;
      chip_selected <= cs_active;
      // Clock edges only reach the core while selected or in two-wire mode.
      serial_clock_rise <= sclk_rise && (is_i2c || cs_active);
      serial_clock_fall <= sclk_fall && (is_i2c || cs_active);
      serial_data_in <= sda_s;
    end
  end

  // Pin driver and core output checks; the outputs are registered, so each looks one cycle back, the strap check two.
  AST_UPPER_NOT_DRIVEN_I2C: assert property (@(posedge clk) disable iff (rst)
    $past(is_i2c) |-> address_select_upper_oe_n)
    else $error("Upper address pin driven in two-wire mode.");
  AST_DATA_INPUT_SPI4: assert property (@(posedge clk) disable iff (rst)
    $past(is_spi4) |-> data_pin_oe_n)
    else $error("Data pin driven in 4-wire SPI.");
  AST_SDO_FLOATS: assert property (@(posedge clk) disable iff (rst)
    (is_spi4 && lower_s) |=> address_select_upper_oe_n)
    else $error("Serial output driven with chip select high.");
  AST_SDO_DRIVES: assert property (@(posedge clk) disable iff (rst)
    (is_spi4 && !lower_s) |=> (!address_select_upper_oe_n && address_select_upper_out == $past(core_data_out)))
    else $error("Serial output not driven while selected.");
  AST_MODE_FOLLOWS_STRAP: assert property (@(posedge clk) disable iff (rst)
    sel_s ##1 sel_s |=> i2c_mode)
    else $error("Mode does not follow strap.");
  AST_SDA_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
    $past(is_i2c) && !data_pin_oe_n |-> !data_pin_out)
    else $error("Data pin driven high in two-wire mode.");
  AST_ADDRESS_BITS: assert property (@(posedge clk) disable iff (rst)
    is_i2c |=> target_address == {`SHPS_ADDR_HI, $past(upper_s), $past(lower_s)})
    else $error("Target address low bits wrong.");
  AST_NO_CLOCK_UNSELECTED: assert property (@(posedge clk) disable iff (rst)
    (!is_i2c && lower_s) |=> !serial_clock_rise && !serial_clock_fall)
    else $error("Clock edge passed without chip select.");
  AST_SPI3_SHARED: assert property (@(posedge clk) disable iff (rst)
    (is_spi3 && !core_data_drive) |=> data_pin_oe_n)
    else $error("Shared line driven without core request.");

  // Start-up and core-side checks.
  // The mode stays two-wire until the synchronisers have settled.
  AST_HOLD_TWO_WIRE_AT_START: assert property (@(posedge clk) disable iff (rst)
    !settled |=> is_i2c)
    else $error("Mode left two-wire before the pins settled.");
  // A clock rise pulse lasts exactly one cycle.
  AST_RISE_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    serial_clock_rise |=> !serial_clock_rise)
    else $error("Clock rise pulse longer than one cycle.");
  // A clock fall pulse lasts exactly one cycle.
  AST_FALL_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    serial_clock_fall |=> !serial_clock_fall)
    else $error("Clock fall pulse longer than one cycle.");
  // Rise and fall can never be reported together.
  AST_EDGES_EXCLUSIVE: assert property (@(posedge clk) disable iff (rst)
    !(serial_clock_rise && serial_clock_fall))
    else $error("Clock rise and fall reported together.");
  // Chip select reaches the core whenever the lower pin is low in SPI.
  AST_CS_FOLLOWS_PIN: assert property (@(posedge clk) disable iff (rst)
    (!is_i2c && !lower_s) |=> chip_selected)
    else $error("Chip select not reported while the pin is low.");
  // Outside two-wire mode no target address is offered.
  AST_SPI_ADDRESS_ZERO: assert property (@(posedge clk) disable iff (rst)
    !is_i2c |=> target_address == 7'h00)
    else $error("Target address offered in SPI mode.");
endmodule
`default_nettype wire

// ==== sim/shps_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host side: makes the serial clock and resolves the shared wires.
module shps_host_model (
  // Clock and frame control.
  input wire logic clk,
  input wire logic run,
  // Host levels and device drivers.
  input wire logic host_d,
  input wire logic host_upper,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic up_o,
  input wire logic up_oe_n,
  // Resolved pins.
  output logic sclk,
  output logic sda,
  output logic upper
);
  logic [1:0] cnt;
  // The clock stands low outside frames, so no stray edge can reach the device.
  always_ff @(posedge clk) begin
    cnt <= run ? cnt + 2'h1 : 2'h0;
    sclk <= run & (sclk ^ (cnt == 2'h3));
  end
  // Either party may pull the data line low; otherwise the host level shows.
  assign sda = dev_oe_n ? host_d : (dev_o & host_d);
  assign upper = up_oe_n ? host_upper : up_o;
endmodule
`default_nettype wire

// ==== sim/serial_host_port_pin_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_host_port_pin_select_tb;
  logic clk, rst, run;
  logic [7:0] pins;
  wire logic sel, four, lower, host_upper, host_d, c_out, c_drive, c_low;
  wire logic sclk, sda, upper, d_o, d_oe_n, u_o, u_oe_n, i2c, cs_on, rise, fall, sdi;
  wire logic [6:0] addr;
  int n_fail = 0;
  int num_checks = 0;
  int n_rise = 0;
  int n_fall = 0;
  assign {sel, four, lower, host_upper, host_d, c_out, c_drive, c_low} = pins;
  shps_pin_select i_dut (.clk(clk), .rst(rst), .protocol_select(sel), .spi_four_wire(four),
    .serial_clock_pin(sclk), .data_pin_in(sda), .address_select_upper_in(upper), .address_select_lower_pin(lower),
    .data_pin_out(d_o), .data_pin_oe_n(d_oe_n), .address_select_upper_out(u_o),
    .address_select_upper_oe_n(u_oe_n), .i2c_mode(i2c), .target_address(addr), .chip_selected(cs_on),
    .serial_clock_rise(rise), .serial_clock_fall(fall), .serial_data_in(sdi), .core_data_out(c_out),
    .core_data_drive(c_drive), .core_sda_pull_low(c_low));
  shps_host_model i_host (.clk(clk), .run(run), .host_d(host_d), .host_upper(host_upper), .dev_o(d_o),
    .dev_oe_n(d_oe_n), .up_o(u_o), .up_oe_n(u_oe_n), .sclk(sclk), .sda(sda), .upper(upper));
  // Count the clock pulses the device reports.
  always @(posedge clk) begin
    if (rise === 1'b1) n_rise++;
    if (fall === 1'b1) n_fall++;
  end
  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkv(input string what, input logic [6:0] exp, input logic [6:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pin order: select, four-wire, lower, upper, data, core out, core drive, core pull.
  // Six edges cover the two sync flops plus the mode and output stages.
  task automatic setp(input logic [7:0] p);
    @(posedge clk);
    pins <= p;
    repeat (6) @(posedge clk);
    // Look at settled outputs, away from the edge that launches them.
    @(negedge clk);
  endtask
  task automatic t_i2c;
    setp(8'b10011001);
    chk1("mode", 1'b1, i2c);
    chkv("address", {5'h1a, 2'b10}, addr);
    chk1("upper oe_n", 1'b1, u_oe_n);
    chk1("sda pull", 1'b0, d_o | d_oe_n);
    setp(8'b10011000);
    chk1("sda release", 1'b1, d_oe_n & sdi);
  endtask
  task automatic t_spi4;
    setp(8'b01011100);
    chk1("mode", 1'b0, i2c);
    chkv("spi address", 7'h00, addr);
    chk1("sdo high", 1'b1, u_o & ~u_oe_n & cs_on & sdi);
    setp(8'b01011010);
    chk1("sdo low", 1'b0, u_o | u_oe_n);
    chk1("sdi oe_n", 1'b1, d_oe_n);
    setp(8'b01111010);
    chk1("sdo float", 1'b1, u_oe_n & ~cs_on);
  endtask
  task automatic t_spi3;
    setp(8'b00011010);
    chk1("sdio drive", 1'b0, d_o | d_oe_n | ~u_oe_n);
    setp(8'b00111010);
    chk1("sdio idle", 1'b1, d_oe_n);
  endtask
  // One frame of seven link clock periods at 800 ns.
  task automatic t_clk(input logic [7:0] p, input logic [6:0] exp);
    setp(p);
    @(negedge clk) n_rise = 0;
    n_fall = 0;
    @(posedge clk) run <= 1'b1;
    repeat (58) @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    chkv("clock rises", exp, 7'(n_rise));
    chkv("clock falls", exp, 7'(n_fall));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Reset for twelve cycles, then one task per scenario.
  initial begin
    rst = 1'b1;
    run = 1'b0;
    pins = 8'b10011000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_i2c;
    t_spi4;
    t_spi3;
    t_clk(8'b00011000, 7'h07);
    t_clk(8'b00111000, 7'h00);
    t_clk(8'b10111000, 7'h07);
    complete_run;
  end
endmodule
`default_nettype wire
